// file: src/smsp_defs.svh
// constants of the byte-wide serial port: offsets, fields, counts
// assumes a 32-bit AHB-Lite bus and a 100 MHz system clock
`ifndef SMSP_DEFS_SVH
`define SMSP_DEFS_SVH

// ==========================================================
// register offsets
`define SMSP_OFF_CTRL 8'h00
`define SMSP_OFF_STAT 8'h04
`define SMSP_OFF_DATA 8'h08

// ==========================================================
// control fields
`define SMSP_CTRL_IRQEN 7
`define SMSP_CTRL_ON 6
`define SMSP_CTRL_LSB 5
`define SMSP_CTRL_CONTROLLER_SELECT 4
`define SMSP_CTRL_CLOCK_IDLE_LEVEL 3
`define SMSP_CTRL_CLOCK_SAMPLE_PHASE 2
`define SMSP_CTRL_RATE_HI 1
`define SMSP_CTRL_RATE_LO 0

// ==========================================================
// status fields
`define SMSP_STAT_DONE 7
`define SMSP_STAT_WRITE_COLLISION_FLAG 6
`define SMSP_STAT_DBL 0

// ==========================================================
// reset values
`define SMSP_CTRL_RST 8'h00
`define SMSP_DBL_RST 1'b0
`define SMSP_SYNC_RST 4'h8

// ==========================================================
// half sck period minus one, in system clocks, then the last edge and bit indices
`define SMSP_HALF_M1_DIV4 6'h01
`define SMSP_HALF_M1_DIV16 6'h07
`define SMSP_HALF_M1_DIV64 6'h1f
`define SMSP_HALF_M1_DIV128 6'h3f
`define SMSP_HALF_M1_DIV2 6'h00
`define SMSP_HALF_M1_DIV8 6'h03
`define SMSP_HALF_M1_DIV32 6'h0f
`define SMSP_LAST_EDGE 4'hf
`define SMSP_LAST_BIT 3'h7

`endif

// file: src/smsp_pkg.sv
// types shared by the serial port and its pin synchroniser
// assumes smsp_defs.svh is on the include path
package smsp_pkg;

  typedef enum logic {
    SMSP_SLAVE = 1'b0,
    SMSP_MASTER = 1'b1
  } smsp_role_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
  } smsp_sync_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic rateDouble;
    logic done;
    logic write_collision_flag;
    logic armed;
    logic busy;
    logic [7:0] sh;
    logic [7:0] rxBuf;
    logic txBit;
    logic [3:0] edgeCnt;
    logic [5:0] divCnt;
    logic [2:0] bitCnt;
    logic sckPrev;
    logic pend;
    logic wr;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic sckO;
    logic sckOe;
    logic mosiO;
    logic mosiOe;
    logic misoO;
    logic misoOe;
    logic irq;
  } smsp_state_t;

endpackage

// file: src/smsp_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs come straight from pins, any timing
`timescale 1ns/10ps
`include "smsp_defs.svh"
module smsp_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins in, filtered levels out
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut
);
  import smsp_pkg::*;

  smsp_sync_t s_q;
  smsp_sync_t s_d;

  // ========================================================
  // stages: the first stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.s1 = pinIn;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < 4; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.filt[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.s1 <= `SMSP_SYNC_RST;
      s_q.s2 <= `SMSP_SYNC_RST;
      s_q.s3 <= `SMSP_SYNC_RST;
      s_q.filt <= `SMSP_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinOut = s_q.filt;

endmodule

// file: src/smsp_port.sv
// byte-wide full-duplex serial port, master or slave, on AHB-Lite
// assumes pin direction bits come from the port logic outside;
// our enables below already include them
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "smsp_defs.svh"
module smsp_port (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu side
  input wire logic globalIrqEn,
  input wire logic irqAck,
  output logic irq,
  // user direction bits of the four pins
  input wire logic ddrMosi,
  input wire logic ddrMiso,
  input wire logic ddrSck,
  input wire logic ddrSs,
  // pins
  input wire logic mosiI,
  output logic mosiO,
  output logic mosiOe,
  input wire logic misoI,
  output logic misoO,
  output logic misoOe,
  input wire logic sckI,
  output logic sckO,
  output logic sckOe,
  input wire logic ssI
);
  import smsp_pkg::*;

  smsp_state_t s_q;
  smsp_state_t s_d;
  logic [3:0] pinSync;
  logic ssF;
  logic sckF;
  logic mosiF;
  logic misoF;

  // ========================================================
  // pin synchronisers
  smsp_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn({ssI, sckI, mosiI, misoI}),
    .pinOut(pinSync)
  );

  assign ssF = pinSync[3];
  assign sckF = pinSync[2];
  assign mosiF = pinSync[1];
  assign misoF = pinSync[0];

  // ========================================================
  // helpers
  function automatic logic [5:0] halfM1(input logic dbl,
                                        input logic [1:0] rate);
    logic [5:0] r;
    r = `SMSP_HALF_M1_DIV4;
    case ({dbl, rate})
      3'h0: r = `SMSP_HALF_M1_DIV4;
      3'h1: r = `SMSP_HALF_M1_DIV16;
      3'h2: r = `SMSP_HALF_M1_DIV64;
      3'h3: r = `SMSP_HALF_M1_DIV128;
      3'h4: r = `SMSP_HALF_M1_DIV2;
      3'h5: r = `SMSP_HALF_M1_DIV8;
      3'h6: r = `SMSP_HALF_M1_DIV32;
      3'h7: r = `SMSP_HALF_M1_DIV64;
      default: r = `SMSP_HALF_M1_DIV4;
    endcase
    return r;
  endfunction

  function automatic logic firstBit(input logic [7:0] sh,
                                    input logic lsb);
    return lsb ? sh[0] : sh[7];
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] sh,
                                         input logic b,
                                         input logic lsb);
    return lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // ========================================================
  // next state
  always_comb begin
    logic on;
    logic lsb;
    logic clock_idle_level;
    logic clock_sample_phase;
    smsp_role_t role;
    logic dataWr;
    logic dataAcc;
    logic statRd;
    logic doneSet;
    logic leading;
    logic sampleNow;
    logic sckRise;
    logic sckFall;
    logic [7:0] shv;
    on = 1'b0;
    lsb = 1'b0;
    clock_idle_level = 1'b0;
    clock_sample_phase = 1'b0;
    role = SMSP_SLAVE;
    dataWr = 1'b0;
    dataAcc = 1'b0;
    statRd = 1'b0;
    doneSet = 1'b0;
    leading = 1'b0;
    sampleNow = 1'b0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    shv = 8'h00;
    s_d = s_q;
    s_d.hresp = 1'b0;

    // ------------------------------------------------------
    // bus data phase: one wait state, then the answer
    if (s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.hready = 1'b1;
      s_d.hrdata = 32'h0000_0000;
      if (s_q.wr) begin
        case (s_q.addr)
          `SMSP_OFF_CTRL: s_d.ctrl = hwdata[7:0];
          `SMSP_OFF_STAT: s_d.rateDouble = hwdata[`SMSP_STAT_DBL];
          `SMSP_OFF_DATA: begin
            dataWr = 1'b1;
            dataAcc = 1'b1;
          end
          default: ;
        endcase
      end else begin
        case (s_q.addr)
          `SMSP_OFF_CTRL: s_d.hrdata = {24'h00_0000, s_q.ctrl};
          `SMSP_OFF_STAT: begin
            statRd = 1'b1;
            s_d.hrdata = {24'h00_0000, s_q.done, s_q.write_collision_flag,
                          5'h00, s_q.rateDouble};
          end
          `SMSP_OFF_DATA: begin
            dataAcc = 1'b1;
            s_d.hrdata = {24'h00_0000, s_q.rxBuf};
          end
          default: ;
        endcase
      end
    end
    if (hsel && htrans[1] && hready) begin
      s_d.pend = 1'b1;
      s_d.hready = 1'b0;
      s_d.wr = hwrite;
      s_d.addr = haddr[7:0];
      if (haddr[31:8] != 24'h00_0000) begin
        s_d.addr = 8'hff;
      end
    end

    // ------------------------------------------------------
    // flag clearing; any set further down wins
    if (dataAcc && s_q.armed) begin
      s_d.done = 1'b0;
      s_d.write_collision_flag = 1'b0;
      s_d.armed = 1'b0;
    end
    if (statRd && (s_q.done || s_q.write_collision_flag)) begin
      s_d.armed = 1'b1;
    end
    if (irqAck) begin
      s_d.done = 1'b0;
    end

    // engine runs on the settings in force this cycle
    on = s_q.ctrl[`SMSP_CTRL_ON];
    lsb = s_q.ctrl[`SMSP_CTRL_LSB];
    clock_idle_level = s_q.ctrl[`SMSP_CTRL_CLOCK_IDLE_LEVEL];
    clock_sample_phase = s_q.ctrl[`SMSP_CTRL_CLOCK_SAMPLE_PHASE];
    role = smsp_role_t'(s_q.ctrl[`SMSP_CTRL_CONTROLLER_SELECT]);
    sckRise = sckF && !s_q.sckPrev;
    sckFall = !sckF && s_q.sckPrev;
    s_d.sckPrev = sckF;
    shv = s_q.sh;

    // ------------------------------------------------------
    // serial engine
    if (!on) begin
      // nothing shifts while the port is off
      s_d.busy = 1'b0;
      s_d.edgeCnt = 4'h0;
      s_d.divCnt = 6'h00;
      s_d.bitCnt = 3'h0;
      s_d.sckO = clock_idle_level;
      if (dataWr) begin
        s_d.sh = hwdata[7:0];
        s_d.txBit = firstBit(hwdata[7:0], lsb);
      end
    end else if (role == SMSP_MASTER) begin
      if (!ddrSs && !ssF) begin
        // another master selected us: back off at once
        s_d.ctrl[`SMSP_CTRL_CONTROLLER_SELECT] = 1'b0;
        doneSet = 1'b1;
        s_d.busy = 1'b0;
        s_d.edgeCnt = 4'h0;
        s_d.divCnt = 6'h00;
        s_d.sckO = clock_idle_level;
        if (dataWr) begin
          s_d.sh = hwdata[7:0];
          s_d.txBit = firstBit(hwdata[7:0], lsb);
        end
      end else if (s_q.busy) begin
        if (dataWr) begin
          s_d.write_collision_flag = 1'b1;
        end
        if (s_q.divCnt == halfM1(s_q.rateDouble,
                                 s_q.ctrl[1:0])) begin
          s_d.divCnt = 6'h00;
          s_d.sckO = !s_q.sckO;
          leading = !s_q.edgeCnt[0];
          sampleNow = leading ^ clock_sample_phase;
          if (sampleNow) begin
            // miso lags the pin by the synchroniser depth
            shv = shiftIn(s_q.sh, misoF, lsb);
            s_d.sh = shv;
          end else begin
            s_d.txBit = firstBit(s_q.sh, lsb);
          end
          s_d.edgeCnt = s_q.edgeCnt + 4'h1;
          if (s_q.edgeCnt == `SMSP_LAST_EDGE) begin
            s_d.busy = 1'b0;
            s_d.edgeCnt = 4'h0;
            s_d.rxBuf = shv;
            doneSet = 1'b1;
          end
        end else begin
          s_d.divCnt = s_q.divCnt + 6'h01;
        end
      end else begin
        s_d.sckO = clock_idle_level;
        if (dataWr) begin
          s_d.sh = hwdata[7:0];
          s_d.txBit = firstBit(hwdata[7:0], lsb);
          s_d.busy = 1'b1;
          s_d.divCnt = 6'h00;
          s_d.edgeCnt = 4'h0;
        end
      end
    end else begin
      // slave: select high holds shifter logic in reset
      s_d.sckO = clock_idle_level;
      if (ssF) begin
        s_d.bitCnt = 3'h0;
        s_d.busy = 1'b0;
        s_d.txBit = firstBit(s_q.sh, lsb);
        if (dataWr) begin
          s_d.sh = hwdata[7:0];
          s_d.txBit = firstBit(hwdata[7:0], lsb);
        end
      end else begin
        if (dataWr && s_q.busy) begin
          s_d.write_collision_flag = 1'b1;
        end else if (dataWr) begin
          s_d.sh = hwdata[7:0];
          s_d.txBit = firstBit(hwdata[7:0], lsb);
        end
        if (sckRise || sckFall) begin
          leading = clock_idle_level ? sckFall : sckRise;
          sampleNow = leading ^ clock_sample_phase;
          s_d.busy = 1'b1;
          if (sampleNow) begin
            shv = shiftIn(s_q.sh, mosiF, lsb);
            s_d.sh = shv;
            s_d.bitCnt = s_q.bitCnt + 3'h1;
            if (s_q.bitCnt == `SMSP_LAST_BIT) begin
              s_d.rxBuf = shv;
              s_d.busy = 1'b0;
              doneSet = 1'b1;
            end
          end else begin
            s_d.txBit = firstBit(s_q.sh, lsb);
          end
        end
      end
    end

    if (doneSet) begin
      s_d.done = 1'b1;
    end

    // ------------------------------------------------------
    // registered pin controls and interrupt
    s_d.irq = s_d.ctrl[`SMSP_CTRL_IRQEN] && s_d.done
              && globalIrqEn;
    s_d.mosiO = s_d.txBit;
    s_d.misoO = s_d.txBit;
    // select is never driven here; as an output it is plain port
    // logic outside
    s_d.sckOe = s_d.ctrl[`SMSP_CTRL_ON]
                && s_d.ctrl[`SMSP_CTRL_CONTROLLER_SELECT] && ddrSck;
    s_d.mosiOe = s_d.ctrl[`SMSP_CTRL_ON]
                 && s_d.ctrl[`SMSP_CTRL_CONTROLLER_SELECT] && ddrMosi;
    s_d.misoOe = s_d.ctrl[`SMSP_CTRL_ON]
                 && !s_d.ctrl[`SMSP_CTRL_CONTROLLER_SELECT]
                 && !ssF && ddrMiso;
  end

  // ========================================================
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ctrl <= `SMSP_CTRL_RST;
      s_q.rateDouble <= `SMSP_DBL_RST;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================
  // outputs, all straight from the state register
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp = s_q.hresp;
  assign irq = s_q.irq;
  assign mosiO = s_q.mosiO;
  assign mosiOe = s_q.mosiOe;
  assign misoO = s_q.misoO;
  assign misoOe = s_q.misoOe;
  assign sckO = s_q.sckO;
  assign sckOe = s_q.sckOe;

endmodule

// file: sim/smsp_port_assertions.sv
// timing checker of the serial port, seen from its ports only
// assumes it is bound onto smsp_port and hready follows hreadyout
`timescale 1ns/10ps
module smsp_port_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // cpu side
  input wire logic globalIrqEn,
  input wire logic irqAck,
  input wire logic irq,
  // pins
  input wire logic ddrSck,
  input wire logic ddrSs,
  input wire logic ssI,
  input wire logic sckO,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic taken;
  logic [4:0] togCnt_q;
  assign taken = hsel && htrans[1] && hready;
  // =========================================
  // sck edges since the last bus write
  // a polarity write adds one edge, so any write restarts the count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      togCnt_q <= 5'h00;
    else if (taken && hwrite)
      togCnt_q <= 5'h00;
    else if (sckOe && $changed(sckO) && togCnt_q != 5'h1f)
      togCnt_q <= togCnt_q + 5'h01;
  end
  // =========================================
  // properties
  chk_sck_count: assert property (togCnt_q <= 5'h10)
    else $error("sck ran past sixteen edges");
  chk_wait_state: assert property (
    taken |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  chk_rsvd_zero: assert property (
    taken && !hwrite && haddr == 32'h04 |->
      ##2 hrdata[5:1] == 5'h00 && hrdata[31:8] == 24'h0)
    else $error("status reserved bits not zero");
  chk_irq_gate: assert property (irq |-> $past(globalIrqEn))
    else $error("irq without global enable");
  chk_irq_ack: assert property (irqAck |-> ##2 !irq)
    else $error("irq stays after acknowledge");
  chk_sck_dir: assert property (sckOe |-> $past(ddrSck))
    else $error("sck driven while user direction is input");
  chk_roles_apart: assert property (
    misoOe |-> !sckOe && !mosiOe)
    else $error("slave drives a pin other than miso");
  chk_miso_select: assert property ($rose(misoOe) |-> !ssI)
    else $error("miso driven while not selected");
  chk_contention_drop: assert property (
    !ssI && !ddrSs |-> ##[0:12] !sckOe && !mosiOe)
    else $error("master kept pins under select contention");
endmodule

// file: sim/smsp_spi_peer.sv
// behavioural far-side slave for master-mode transfers
// assumes the bench selects it and sets the same mode as the port
`timescale 1ns/10ps
module smsp_spi_peer (
  // link
  input wire logic sck,
  input wire logic selN,
  input wire logic mosi,
  output logic miso,
  // mode and data
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic lsb,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte
);
  int n = 0;
  function automatic logic pick(int i);
    return lsb ? txByte[i] : txByte[7 - i];
  endfunction
  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
  end
  // phase 0 needs the first bit before the first edge
  always @(negedge selN) begin
    n = 0;
    if (!clock_sample_phase)
      miso = pick(0);
  end
  // released line must not echo the last bit
  always @(posedge selN) miso = ~miso;
  always @(sck) begin
    if (!selN && sck == ~(clock_idle_level ^ clock_sample_phase)) begin
      rxByte = lsb ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      n = n + 1;
    end else if (!selN && n < 8)
      miso = pick(n);
  end
endmodule

// file: sim/testbench.sv
// self-checking bench: bus tasks drive the port, a peer answers in
// master mode and the bench itself plays the external master
`timescale 1ns/10ps
module testbench;
  // =========================================
  // clock, bus and pins
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq, globalIrqEn = 1'b0, irqAck = 1'b0;
  logic ddrMosi = 1'b1, ddrMiso = 1'b0, ddrSck = 1'b1, ddrSs = 1'b1;
  logic ssI = 1'b1, extSck = 1'b0, tbMosi = 1'b0, peerSelN = 1'b1;
  logic mosiO, mosiOe, misoO, misoOe, sckO, sckOe, peerMiso;
  logic clock_idle_level = 1'b0, clock_sample_phase = 1'b0, lsb = 1'b0;
  logic [7:0] peerTx = 8'h00, peerRx;
  logic mosiW, misoW, sckW;
  int miscompares = 0, checksDone = 0, h;
  int halfTab [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
  always #5 clk = ~clk;
  assign mosiW = mosiOe ? mosiO : tbMosi;
  assign misoW = misoOe ? misoO : peerMiso;
  assign sckW = sckOe ? sckO : extSck;
  smsp_port dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .globalIrqEn(globalIrqEn),
    .irqAck(irqAck), .irq(irq), .ddrMosi(ddrMosi), .ddrMiso(ddrMiso),
    .ddrSck(ddrSck), .ddrSs(ddrSs), .mosiI(mosiW), .mosiO(mosiO),
    .mosiOe(mosiOe), .misoI(misoW), .misoO(misoO), .misoOe(misoOe),
    .sckI(sckW), .sckO(sckO), .sckOe(sckOe), .ssI(ssI));
  smsp_spi_peer peer (.sck(sckW), .selN(peerSelN), .mosi(mosiW),
    .miso(peerMiso), .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .lsb(lsb),
    .txByte(peerTx), .rxByte(peerRx));
  // =========================================
  // tasks
  task automatic chk(input string s, input logic [31:0] seen, e);
    checksDone++;
    if (seen !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    // no local limit: only the watchdog ends a wait
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input string s, input logic [7:0] a,
      input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(s, r, e);
  endtask
  task automatic waitDone;
    logic [31:0] r;
    r = 32'h0;
    while (r[7] !== 1'b1)
      bus(1'b0, 8'h04, 8'h00, r);
  endtask
  task automatic xfer(input logic [7:0] c, tx, rx);
    peerSelN <= 1'b1;
    {lsb, clock_idle_level, clock_sample_phase} <= {c[5], c[3:2]};
    peerTx <= rx;
    wr(8'h00, c);
    peerSelN <= 1'b0;
    @(posedge clk);
    wr(8'h08, tx);
  endtask
  task automatic half(output int n);
    logic b;
    b = sckO;
    while (sckO === b) @(posedge clk);
    b = sckO;
    n = 0;
    while (sckO === b) begin
      @(posedge clk);
      n++;
    end
  endtask
  // bench as external master, mode 0, msb first, eighth rate
  task automatic send(input int n, input logic [7:0] b,
      output logic [7:0] got);
    got = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      tbMosi <= b[i];
      repeat (4) @(posedge clk);
      extSck <= 1'b1;
      repeat (4) @(posedge clk);
      // miso trails sck by the synchroniser depth: read late
      got = {got[6:0], misoW};
      extSck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    tbMosi <= ~tbMosi;
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    conclude();
  end
  // =========================================
  // sequence
  initial begin
    logic [31:0] junk;
    logic [7:0] rxs;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("pins off", 32'({sckOe, mosiOe, misoOe, hresp}), 0);
    rdc("ctrl reset", 8'h00, 32'h0);
    rdc("unmapped", 8'h0c, 32'h0);
    wr(8'h08, 8'h55);
    repeat (40) @(posedge clk);
    rdc("port off", 8'h04, 32'h0);
    wr(8'h04, 8'hff);
    rdc("status bits", 8'h04, 32'h01);
    wr(8'h04, 8'h00);
    ssI <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      xfer(8'h51 | 8'(m << 2) | (m == 3 ? 8'h20 : 8'h00),
        8'hc3 ^ 8'(m), 8'h2d + 8'(m));
      waitDone();
      rdc("done", 8'h04, 32'h80);
      rdc("rx byte", 8'h08, 32'h2d + m);
      chk("peer rx", 32'(peerRx), 32'hc3 ^ m);
      chk("sck idle", 32'(sckO), 32'(m[1]));
      rdc("flag clear", 8'h04, 32'h0);
    end
    rdc("role kept", 8'h00, 32'h7d);
    peerSelN <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(8'h04, 8'(k >> 2));
      wr(8'h00, 8'h50 | 8'(k & 3));
      wr(8'h08, 8'h0f);
      half(h);
      chk("half period", h, halfTab[k]);
      waitDone();
      bus(1'b0, 8'h08, 8'h00, junk);
    end
    wr(8'h04, 8'h00);
    xfer(8'h51, 8'h81, 8'h18);
    wr(8'h08, 8'h7e);
    waitDone();
    rdc("collision", 8'h04, 32'hc0);
    rdc("kept byte", 8'h08, 32'h18);
    chk("peer first", 32'(peerRx), 32'h81);
    rdc("both clear", 8'h04, 32'h0);
    xfer(8'hd1, 8'h00, 8'h00);
    waitDone();
    chk("irq masked", 32'(irq), 32'h0);
    globalIrqEn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq raised", 32'(irq), 32'h1);
    irqAck <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq acked", 32'(irq), 32'h0);
    rdc("done acked", 8'h04, 32'h0);
    globalIrqEn <= 1'b0;
    // select settles high before it turns into an input
    ssI <= 1'b1;
    peerSelN <= 1'b1;
    repeat (8) @(posedge clk);
    ddrSs <= 1'b0;
    wr(8'h00, 8'h51);
    rdc("master held", 8'h00, 32'h51);
    ssI <= 1'b0;
    repeat (12) @(posedge clk);
    chk("pins freed", 32'({sckOe, mosiOe}), 32'h0);
    rdc("master lost", 8'h00, 32'h41);
    rdc("lost flag", 8'h04, 32'h80);
    ssI <= 1'b1;
    // synchronised select must be high before miso may drive
    repeat (8) @(posedge clk);
    {ddrMosi, ddrSck, ddrMiso} <= 3'h1;
    wr(8'h00, 8'h40);
    wr(8'h08, 8'h96);
    rdc("cleared", 8'h04, 32'h0);
    send(8, 8'hff, rxs);
    rdc("ss high idle", 8'h04, 32'h0);
    chk("miso off", 32'(misoOe), 32'h0);
    ssI <= 1'b0;
    repeat (8) @(posedge clk);
    chk("slave pins", 32'({misoOe, sckOe, mosiOe}), 32'h4);
    send(4, 8'hf0, rxs);
    ssI <= 1'b1;
    repeat (8) @(posedge clk);
    ssI <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8'h08, 8'h3c);
    send(8, 8'h5a, rxs);
    chk("slave tx", 32'(rxs), 32'h3c);
    rdc("slave done", 8'h04, 32'h80);
    rdc("slave byte", 8'h08, 32'h5a);
    conclude();
  end
endmodule
bind smsp_port smsp_port_assertions smspChk (.clk(clk),
  .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .globalIrqEn(globalIrqEn), .irqAck(irqAck),
  .irq(irq), .ddrSck(ddrSck), .ddrSs(ddrSs), .ssI(ssI), .sckO(sckO),
  .sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe));
